// file: rtl/ppbg_ctl.sv
`timescale 1ns/1ps
// Functional notes
// RQ1: primary latency plus 2-clock write preamble adds one
// RQ2: latency per speed bin; 2-clock needs 2400+
// RQ3: write recovery one clock higher in 2-clock mode
// RQ4: writes keep short and long column spacing
// RQ5: no 5-clock column gap with 2-clock write preamble; code allows a 5-clock gap when CTL_CRC is set
// RQ6: write preamble select: 0 one clock, 1 two
// RQ7: read preamble select: 0 one clock, 1 two
// RQ8: no 5-clock column gap with 2-clock read preamble
// RQ9: no 6-clock gap with 2-clock write and checksum
// RQ10: training only in multipurpose register access mode
// RQ11: training bit set enters, cleared leaves
// RQ12: after output delay strobes valid, data held high
// RQ13: strobes parked until page-zero read, then toggle
// RQ14: write burst ends with half-clock postamble
// RQ15: read burst ends with half-clock postamble
// RQ16: x8 four groups, x16 two, four banks each
// RQ17: other group short spacing, same group long
// RQ18: clock count or time, whichever longer
// RQ19: 2-clock write preamble starts strobe one earlier
module ppbg_ctl
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   ppbg_if.ctl bus
);
   typedef enum logic [1:0]
   {
      PPBG_IDLE = 2'b00,
      PPBG_WAIT = 2'b01,
      PPBG_XFER = 2'b11
   } ppbg_st_t;

   typedef struct packed {
      logic ck;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [13:0] ctrl;
      logic [63:0] wd;
      logic [63:0] rd;
      logic refused;
      logic pend;
      logic [2:0] op;
      logic [1:0] pbg;
      logic [1:0] pba;
      ppbg_st_t st;
      logic [5:0] n;
      logic [3:0] gap;
      logic [1:0] last_bg;
      logic mpr_live;
      logic train_live;
      logic wpre_live;
      logic rpre_live;
      logic [2:0] wlf;
      ppbg_pkg::ppbg_cmd_t cmd;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [13:0] addr;
      logic dqs_t;
      logic dqs_c;
      logic dqs_oe;
      logic [15:0] dq;
      logic dq_oe;
   } ppbg_ctl_t;

   ppbg_ctl_t s_q;
   ppbg_ctl_t s_d;

   function automatic logic addr_ok(input logic [7:0] a);
      return a == ppbg_pkg::CTRL_OFS || a == ppbg_pkg::CMD_OFS ||
         a == ppbg_pkg::STAT_OFS || a == ppbg_pkg::WD0_OFS ||
         a == ppbg_pkg::WD1_OFS || a == ppbg_pkg::RD0_OFS ||
         a == ppbg_pkg::RD1_OFS;
   endfunction

   always_comb
   begin
      logic pre2_ok;
      logic wpre;
      logic rpre;
      logic [3:0] need;
      logic gap_ok;
      logic [2:0] wlf;
      logic [6:0] rel;
      logic [4:0] lat;
      logic busy;
      pre2_ok = ppbg_pkg::SPEED_BIN >= ppbg_pkg::PRE2_MIN_BIN; // RQ2
      wpre = s_q.ctrl[ppbg_pkg::CTL_WPRE] & pre2_ok; // RQ2
      rpre = s_q.ctrl[ppbg_pkg::CTL_RPRE] & pre2_ok;
      wlf = s_q.ctrl[ppbg_pkg::CTL_WLF +: 3];
      busy = s_q.pend | (s_q.st != PPBG_IDLE);
      need = (s_q.pbg == s_q.last_bg) ? ppbg_pkg::CCD_L_NCK
         : ppbg_pkg::CCD_S_NCK; // RQ4 RQ17 RQ18
      gap_ok = s_q.gap >= need &&
         !((s_q.wpre_live && !s_q.ctrl[ppbg_pkg::CTL_CRC] ||
            s_q.rpre_live) && s_q.gap == ppbg_pkg::GAP_FORBID_PRE) &&
         !(s_q.wpre_live && s_q.ctrl[ppbg_pkg::CTL_CRC] &&
            s_q.gap == ppbg_pkg::GAP_FORBID_CRC); // RQ5 RQ8 RQ9
      lat = (s_q.op == ppbg_pkg::OP_WR) ? ppbg_pkg::cwl_decode(s_q.wlf)
         : ppbg_pkg::READ_LATENCY;
      // beat b driven at the fall just before device rise latency+1+b
      rel = {1'b0, s_q.n} - {2'h0, lat};
      s_d = s_q;
      s_d.ck = ~s_q.ck;
      s_d.pready = 1'b0;
      if (psel && !penable)
      begin
         s_d.pready = 1'b1;
         s_d.pslverr = !addr_ok(paddr);
         unique case (paddr)
            ppbg_pkg::CTRL_OFS: s_d.prdata = {18'h0, s_q.ctrl};
            ppbg_pkg::STAT_OFS:
               s_d.prdata = {29'h0, s_q.train_live, s_q.refused, busy};
            ppbg_pkg::WD0_OFS: s_d.prdata = s_q.wd[31:0];
            ppbg_pkg::WD1_OFS: s_d.prdata = s_q.wd[63:32];
            ppbg_pkg::RD0_OFS: s_d.prdata = s_q.rd[31:0];
            ppbg_pkg::RD1_OFS: s_d.prdata = s_q.rd[63:32];
            default: s_d.prdata = 32'h0;
         endcase
      end
      if (psel && penable && s_q.pready && pwrite)
      begin
         unique case (paddr)
            ppbg_pkg::CTRL_OFS: s_d.ctrl = pwdata[13:0];
            ppbg_pkg::WD0_OFS: s_d.wd[31:0] = pwdata;
            ppbg_pkg::WD1_OFS: s_d.wd[63:32] = pwdata;
            ppbg_pkg::STAT_OFS:
               if (pwdata[1])
                  s_d.refused = 1'b0;
            ppbg_pkg::CMD_OFS:
               if (!busy)
               begin
                  s_d.pend = 1'b1;
                  s_d.op = pwdata[2:0];
                  s_d.pbg = pwdata[4:3];
                  s_d.pba = pwdata[6:5];
               end
            default: ;
         endcase
      end
      // a command that cannot be taken sets the flag; set beats clear
      if (psel && penable && s_q.pready && pwrite && busy &&
         paddr == ppbg_pkg::CMD_OFS)
         s_d.refused = 1'b1;
      // link work happens as the link clock falls
      if (s_q.ck)
      begin
         s_d.cmd = ppbg_pkg::PPBG_NOP;
         if (s_q.gap != 4'hf)
            s_d.gap = s_q.gap + 4'h1;
         unique case (s_q.st)
            PPBG_IDLE:
               if (s_q.pend)
                  s_d.st = PPBG_WAIT;
            PPBG_WAIT:
            begin
               s_d.pend = 1'b0;
               s_d.st = PPBG_IDLE;
               s_d.addr = 14'h0;
               s_d.bg = 2'h0;
               unique case (s_q.op)
                  ppbg_pkg::OP_WR, ppbg_pkg::OP_RD:
                  begin
                     s_d.pend = !gap_ok;
                     s_d.st = gap_ok ? PPBG_XFER : PPBG_WAIT;
                     if (gap_ok)
                     begin
                        s_d.cmd = (s_q.op == ppbg_pkg::OP_WR) ?
                           ppbg_pkg::PPBG_WR : ppbg_pkg::PPBG_RD;
                        s_d.bg = ppbg_pkg::ORG_X16 ? {1'b0, s_q.pbg[0]}
                           : s_q.pbg; // RQ16
                        s_d.ba = s_q.pba;
                        s_d.last_bg = s_q.pbg;
                        s_d.gap = 4'h1;
                        s_d.n = 6'h00;
                     end
                  end
                  ppbg_pkg::OP_MR0:
                  begin
                     s_d.cmd = ppbg_pkg::PPBG_MRS;
                     s_d.ba = ppbg_pkg::MR0_IDX[1:0];
                     s_d.addr[ppbg_pkg::WRITE_RECOVERY_LSB +: 3] =
                        s_q.ctrl[ppbg_pkg::CTL_WREC +: 3] +
                        {2'h0, wpre}; // RQ3
                  end
                  ppbg_pkg::OP_MR2:
                  begin
                     // saturating: the top code has no room for the extra clock
                     if (wpre && !s_q.ctrl[ppbg_pkg::CTL_ALT] && wlf != 3'h7)
                        wlf = wlf + 3'h1; // RQ1
                     s_d.cmd = ppbg_pkg::PPBG_MRS;
                     s_d.ba = ppbg_pkg::MR2_IDX[1:0];
                     s_d.addr[ppbg_pkg::WRITE_LATENCY_LSB +: 3] = wlf;
                     s_d.wlf = wlf;
                  end
                  ppbg_pkg::OP_MR3:
                  begin
                     s_d.cmd = ppbg_pkg::PPBG_MRS;
                     s_d.ba = ppbg_pkg::MR3_IDX[1:0];
                     s_d.addr[ppbg_pkg::MPR_MODE_BIT] =
                        s_q.ctrl[ppbg_pkg::CTL_MPR];
                     s_d.addr[ppbg_pkg::MPR_PAGE_LSB +: 2] =
                        s_q.ctrl[ppbg_pkg::CTL_PAGE +: 2];
                     s_d.mpr_live = s_q.ctrl[ppbg_pkg::CTL_MPR];
                     s_d.train_live = s_q.train_live &
                        s_q.ctrl[ppbg_pkg::CTL_MPR];
                  end
                  ppbg_pkg::OP_MR4:
                  begin
                     s_d.cmd = ppbg_pkg::PPBG_MRS;
                     s_d.bg = {1'b0, ppbg_pkg::MR4_IDX[2]};
                     s_d.ba = ppbg_pkg::MR4_IDX[1:0];
                     s_d.addr[ppbg_pkg::WRITE_PREAMBLE_SELECT] = wpre; // RQ6
                     s_d.addr[ppbg_pkg::READ_PREAMBLE_SELECT] = rpre; // RQ7
                     s_d.addr[ppbg_pkg::PREAMBLE_TRAINING_ENABLE] =
                        s_q.ctrl[ppbg_pkg::CTL_TRAIN] & s_q.mpr_live; // RQ10 RQ11
                     if (s_q.ctrl[ppbg_pkg::CTL_TRAIN] && !s_q.mpr_live)
                        s_d.refused = 1'b1; // RQ10
                     s_d.wpre_live = wpre;
                     s_d.rpre_live = rpre;
                     s_d.train_live = s_q.ctrl[ppbg_pkg::CTL_TRAIN] &
                        s_q.mpr_live;
                  end
                  default: ;
               endcase
            end
            PPBG_XFER:
            begin
               s_d.n = s_q.n + 6'h01;
               s_d.dqs_oe = 1'b0;
               s_d.dq_oe = 1'b0;
               if (s_q.op == ppbg_pkg::OP_WR)
               begin
                  if ($signed(rel) < 0 &&
                     $signed(rel) >= (s_q.wpre_live ? -7'sd2 : -7'sd1))
                  begin
                     s_d.dqs_oe = 1'b1; // RQ19
                     s_d.dqs_t = 1'b0;
                     s_d.dqs_c = 1'b1;
                  end
                  else if ($signed(rel) >= 0 && rel < 7'h04)
                  begin
                     s_d.dqs_oe = 1'b1;
                     s_d.dqs_t = ~rel[0];
                     s_d.dqs_c = rel[0];
                     s_d.dq_oe = 1'b1;
                     s_d.dq = s_q.wd[16 * rel[1:0] +: 16];
                  end
                  else if (rel == 7'h04)
                  begin
                     s_d.dqs_oe = 1'b1; // RQ14
                     s_d.dqs_t = 1'b0;
                     s_d.dqs_c = 1'b1;
                  end
                  else if (rel == 7'h05)
                     s_d.st = PPBG_IDLE;
               end
               else
               begin
                  // device output is settled half a clock before this edge
                  if ($signed(rel) >= 0 && rel < 7'h04)
                     s_d.rd[16 * rel[1:0] +: 16] = bus.d_dq;
                  else if (rel == 7'h04)
                     s_d.st = PPBG_IDLE; // RQ15
               end
            end
            default: s_d.st = PPBG_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.ctrl <= ppbg_pkg::CTRL_RST;
         s_q.gap <= 4'hf;
      end
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign bus.ck = s_q.ck;
   assign bus.cmd = s_q.cmd;
   assign bus.bank_group_field = s_q.bg;
   assign bus.ba = s_q.ba;
   assign bus.addr = s_q.addr;
   assign bus.c_dqs_t = s_q.dqs_t;
   assign bus.c_dqs_c = s_q.dqs_c;
   assign bus.c_dqs_oe = s_q.dqs_oe;
   assign bus.c_dq = s_q.dq;
   assign bus.c_dq_oe = s_q.dq_oe;
endmodule // ppbg_ctl

// file: pkg/ppbg_pkg.sv
package ppbg_pkg;
   typedef enum logic [2:0]
   {
      PPBG_NOP = 3'h0,
      PPBG_MRS = 3'h1,
      PPBG_WR = 3'h2,
      PPBG_RD = 3'h3
   } ppbg_cmd_t;

   // mode register indices carried on {bank_group_field[0], bank}
   localparam logic [2:0] MR0_IDX = 3'h0;
   localparam logic [2:0] MR2_IDX = 3'h2;
   localparam logic [2:0] MR3_IDX = 3'h3;
   localparam logic [2:0] MR4_IDX = 3'h4;
   localparam int WRITE_PREAMBLE_SELECT = 12;
   localparam int READ_PREAMBLE_SELECT = 11;
   localparam int PREAMBLE_TRAINING_ENABLE = 10;
   localparam int WRITE_RECOVERY_LSB = 9;
   localparam int WRITE_LATENCY_LSB = 3;
   localparam int MPR_MODE_BIT = 2;
   localparam int MPR_PAGE_LSB = 0;

   localparam logic [4:0] READ_LATENCY = 5'h0b;
   localparam logic [5:0] SDO_NCK = 6'h08;
   localparam int BURST_CYC = 4;
   localparam logic ORG_X16 = 1'b0;
   localparam logic [31:0] MPR_PAGE0 = 32'h000f3355;

   localparam int SPEED_BIN = 3200;
   localparam int PRE2_MIN_BIN = 2400;
   localparam int PCLK_PS = 10000;
   localparam int CK_PS = 2 * PCLK_PS;
   localparam int CCD_MIN_NCK = 4;
   localparam int T_CCD_S_PS = 5000;
   localparam int T_CCD_L_PS = 6250;
   localparam int CCD_S_CYC = (T_CCD_S_PS + CK_PS - 1) / CK_PS;
   localparam int CCD_L_CYC = (T_CCD_L_PS + CK_PS - 1) / CK_PS;
   localparam logic [3:0] CCD_S_NCK =
      4'(CCD_S_CYC > CCD_MIN_NCK ? CCD_S_CYC : CCD_MIN_NCK);
   localparam logic [3:0] CCD_L_NCK =
      4'(CCD_L_CYC > CCD_MIN_NCK ? CCD_L_CYC : CCD_MIN_NCK);
   localparam logic [3:0] GAP_FORBID_PRE = 4'h5;
   localparam logic [3:0] GAP_FORBID_CRC = 4'h6;

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] WD0_OFS = 8'h0c;
   localparam logic [7:0] WD1_OFS = 8'h10;
   localparam logic [7:0] RD0_OFS = 8'h14;
   localparam logic [7:0] RD1_OFS = 8'h18;
   localparam int CTL_WPRE = 0;
   localparam int CTL_RPRE = 1;
   localparam int CTL_ALT = 2;
   localparam int CTL_WLF = 3;
   localparam int CTL_WREC = 6;
   localparam int CTL_CRC = 9;
   localparam int CTL_MPR = 10;
   localparam int CTL_PAGE = 11;
   localparam int CTL_TRAIN = 13;
   localparam logic [13:0] CTRL_RST = 14'h0000;
   localparam logic [2:0] OP_WR = 3'h0;
   localparam logic [2:0] OP_RD = 3'h1;
   localparam logic [2:0] OP_MR0 = 3'h2;
   localparam logic [2:0] OP_MR2 = 3'h3;
   localparam logic [2:0] OP_MR3 = 3'h4;
   localparam logic [2:0] OP_MR4 = 3'h5;

   function automatic logic [4:0] cwl_decode(input logic [2:0] f);
      logic [4:0] r;
      r = 5'h09;
      unique case (f)
         3'h0: r = 5'h09;
         3'h1: r = 5'h0a;
         3'h2: r = 5'h0b;
         3'h3: r = 5'h0c;
         3'h4: r = 5'h0e;
         3'h5: r = 5'h10;
         3'h6: r = 5'h12;
         3'h7: r = 5'h14;
      endcase
      return r;
   endfunction
endpackage

// file: pkg/ppbg_if.sv
`timescale 1ns/1ps
interface ppbg_if;
   logic ck;
   ppbg_pkg::ppbg_cmd_t cmd;
   logic [1:0] bank_group_field;
   logic [1:0] ba;
   logic [13:0] addr;
   logic c_dqs_t;
   logic c_dqs_c;
   logic c_dqs_oe;
   logic [15:0] c_dq;
   logic c_dq_oe;
   logic d_dqs_t;
   logic d_dqs_c;
   logic d_dqs_oe;
   logic [15:0] d_dq;
   logic d_dq_oe;
   modport ctl (output ck, cmd, bank_group_field, ba, addr, c_dqs_t,
      c_dqs_c, c_dqs_oe, c_dq, c_dq_oe,
      input d_dqs_t, d_dqs_c, d_dqs_oe, d_dq, d_dq_oe);
   modport dev (input ck, cmd, bank_group_field, ba, addr, c_dqs_t,
      c_dqs_c, c_dqs_oe, c_dq, c_dq_oe,
      output d_dqs_t, d_dqs_c, d_dqs_oe, d_dq, d_dq_oe);
endinterface

// file: rtl/ppbg_dev.sv
`timescale 1ns/1ps
module ppbg_dev
(
   ppbg_if.dev bus,
   input wire logic presetn,
   output logic wr_pre_mode,
   output logic rd_pre_mode,
   output logic train_mode
);
   typedef struct packed {
      logic wr_pre;
      logic rd_pre;
      logic train;
      logic multipurpose_register_page;
      logic [1:0] page;
      logic [2:0] wl_f;
      logic [2:0] wrec;
      logic [5:0] sdo_cnt;
      logic [31:0][4:0] wr_pipe;
      logic [31:0][5:0] rd_pipe;
      logic [63:0] wbuf;
      logic [15:0][63:0] mem;
      logic dqs_t;
      logic dqs_c;
      logic dqs_oe;
      logic [15:0] dq;
      logic dq_oe;
   } ppbg_dev_t;

   ppbg_dev_t s_q;
   ppbg_dev_t s_d;

   function automatic logic [3:0] bidx(input logic [1:0] g,
      input logic [1:0] b);
      return ppbg_pkg::ORG_X16 ? {1'b0, g[0], b} : {g, b}; // RQ16
   endfunction

   always_comb
   begin
      logic [4:0] wl;
      int off;
      int pre;
      logic dat;
      logic prh;
      logic pst;
      logic [1:0] beat;
      logic [5:0] ent;
      wl = ppbg_pkg::cwl_decode(s_q.wl_f);
      off = 0;
      pre = s_q.rd_pre ? 2 : 1; // RQ7
      dat = 1'b0;
      prh = 1'b0;
      pst = 1'b0;
      beat = 2'h0;
      ent = 6'h00;
      s_d = s_q;
      s_d.wr_pipe = {s_q.wr_pipe[30:0], 5'h00};
      s_d.rd_pipe = {s_q.rd_pipe[30:0], 6'h00};
      if (s_q.sdo_cnt != 6'h00)
         s_d.sdo_cnt = s_q.sdo_cnt - 6'h01;
      unique case (bus.cmd)
         ppbg_pkg::PPBG_NOP: ;
         ppbg_pkg::PPBG_MRS:
         begin
            unique case ({bus.bank_group_field[0], bus.ba})
               ppbg_pkg::MR0_IDX:
                  s_d.wrec = bus.addr[ppbg_pkg::WRITE_RECOVERY_LSB +: 3];
               ppbg_pkg::MR2_IDX:
                  s_d.wl_f = bus.addr[ppbg_pkg::WRITE_LATENCY_LSB +: 3];
               ppbg_pkg::MR3_IDX:
               begin
                  s_d.multipurpose_register_page = bus.addr[ppbg_pkg::MPR_MODE_BIT];
                  s_d.page = bus.addr[ppbg_pkg::MPR_PAGE_LSB +: 2];
                  if (!bus.addr[ppbg_pkg::MPR_MODE_BIT])
                     s_d.train = 1'b0; // RQ10
               end
               ppbg_pkg::MR4_IDX:
               begin
                  s_d.wr_pre = bus.addr[ppbg_pkg::WRITE_PREAMBLE_SELECT]; // RQ6
                  s_d.rd_pre = bus.addr[ppbg_pkg::READ_PREAMBLE_SELECT]; // RQ7
                  // ignored outside multipurpose register access
                  s_d.train = bus.addr[ppbg_pkg::PREAMBLE_TRAINING_ENABLE]
                     & s_q.multipurpose_register_page; // RQ10 RQ11
                  if (s_d.train && !s_q.train)
                     s_d.sdo_cnt = ppbg_pkg::SDO_NCK; // RQ12
               end
               default: ;
            endcase
         end
         ppbg_pkg::PPBG_WR:
            s_d.wr_pipe[0] = {1'b1, bidx(bus.bank_group_field, bus.ba)};
         ppbg_pkg::PPBG_RD:
            s_d.rd_pipe[0] = {1'b1, s_q.multipurpose_register_page && s_q.page == 2'h0,
               bidx(bus.bank_group_field, bus.ba)};
         default: ;
      endcase
      // write beats are taken at the edge closing each data cycle
      for (int k = 0; k < 32; k++)
      begin
         if (s_q.wr_pipe[k][4])
         begin
            off = k - int'(wl);
            if (off >= 0 && off < ppbg_pkg::BURST_CYC)
               s_d.wbuf[16 * off +: 16] = bus.c_dq;
            if (off == ppbg_pkg::BURST_CYC - 1)
               s_d.mem[s_q.wr_pipe[k][3:0]] = {bus.c_dq, s_q.wbuf[47:0]};
         end
      end
      // data beats win over preamble and postamble, which both drive the same parked strobe level
      for (int k = 0; k < 32; k++)
      begin
         if (s_d.rd_pipe[k][5])
         begin
            off = k - int'(ppbg_pkg::READ_LATENCY);
            if (off >= 0 && off < ppbg_pkg::BURST_CYC)
            begin
               dat = 1'b1;
               beat = off[1:0];
               ent = s_d.rd_pipe[k];
            end
            else if (off < 0 && off >= -pre)
               prh = 1'b1;
            else if (off == ppbg_pkg::BURST_CYC)
               pst = 1'b1;
         end
      end
      s_d.dqs_oe = 1'b1;
      s_d.dqs_t = 1'b0;
      s_d.dqs_c = 1'b1;
      s_d.dq_oe = 1'b0;
      s_d.dq = 16'hffff;
      if (dat)
      begin
         s_d.dqs_t = ~beat[0]; // RQ13
         s_d.dqs_c = beat[0];
         s_d.dq_oe = 1'b1;
         if (ent[4])
            s_d.dq = {{8{ppbg_pkg::MPR_PAGE0[2 * beat + 1]}},
               {8{ppbg_pkg::MPR_PAGE0[2 * beat]}}}; // RQ13
         else
            s_d.dq = s_q.mem[ent[3:0]][16 * beat +: 16];
      end
      else if (prh || pst)
         s_d.dqs_oe = 1'b1; // RQ15
      else if (s_q.train && s_q.sdo_cnt == 6'h00)
         s_d.dq_oe = 1'b1; // RQ12 RQ13
      else
         s_d.dqs_oe = 1'b0;
   end

   always_ff @(posedge bus.ck or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign bus.d_dqs_t = s_q.dqs_t;
   assign bus.d_dqs_c = s_q.dqs_c;
   assign bus.d_dqs_oe = s_q.dqs_oe;
   assign bus.d_dq = s_q.dq;
   assign bus.d_dq_oe = s_q.dq_oe;
   assign wr_pre_mode = s_q.wr_pre;
   assign rd_pre_mode = s_q.rd_pre;
   assign train_mode = s_q.train;
endmodule // ppbg_dev

// file: bench/ppbg_chk.sv
`timescale 1ns/1ps
module ppbg_chk
(
   input wire logic ck,
   input wire logic presetn,
   input wire ppbg_pkg::ppbg_cmd_t cmd,
   input wire logic [1:0] bank_group_field,
   input wire logic [1:0] ba,
   input wire logic [13:0] addr,
   input wire logic c_dqs_t,
   input wire logic c_dqs_c,
   input wire logic c_dqs_oe,
   input wire logic d_dqs_t,
   input wire logic d_dqs_c,
   input wire logic d_dqs_oe,
   input wire logic [15:0] d_dq
);
   logic col, mrs, mr4;
   logic [3:0] gap_q;
   logic [1:0] grp_q;
   logic wpre_q, rpre_q, train_q, mpr_q;
   assign col = cmd == ppbg_pkg::PPBG_WR || cmd == ppbg_pkg::PPBG_RD;
   assign mrs = cmd == ppbg_pkg::PPBG_MRS;
   assign mr4 = mrs && {bank_group_field[0], ba} == ppbg_pkg::MR4_IDX;
   // modes copied from the wire, so neither end's view is trusted
   always_ff @(posedge ck or negedge presetn)
   begin
      if (!presetn)
         {gap_q, grp_q, wpre_q, rpre_q, train_q, mpr_q} <= 10'h3c0;
      else
      begin
         if (col)
            {gap_q, grp_q} <= {4'h1, bank_group_field};
         else if (gap_q != 4'hf)
            gap_q <= gap_q + 4'h1;
         if (mr4)
            {wpre_q, rpre_q, train_q} <= addr[12:10];
         if (mrs && {bank_group_field[0], ba} == ppbg_pkg::MR3_IDX)
            mpr_q <= addr[2];
      end
   end
   sequence pre_one(t, c);
      !t && c ##1 t;
   endsequence
   sequence pre_two(t, c);
      !t && c ##1 !t && c ##1 t;
   endsequence
   default clocking @(posedge ck); endclocking
   default disable iff (!presetn);
   chk_col_space: assert property (col |-> gap_q >=
      (bank_group_field == grp_q ?
      ppbg_pkg::CCD_L_NCK : ppbg_pkg::CCD_S_NCK))
      else $error("column spacing short");
   chk_rd_gap5: assert property (col && rpre_q |-> gap_q != 4'h5)
      else $error("gap of five with long read preamble");
   chk_train_mpr: assert property (mr4 && addr[10] |-> mpr_q)
      else $error("training outside register mode");
   chk_train_idle: assert property (mr4 && addr[10] |-> ##[1:10]
      d_dqs_oe && !d_dqs_t && d_dqs_c && d_dq == 16'hffff)
      else $error("training idle level late");
   chk_wr_post: assert property ($fell(c_dqs_oe) |->
      !$past(c_dqs_t) && $past(c_dqs_c)) else $error("write postamble");
   chk_rd_post: assert property ($fell(d_dqs_oe) |->
      !$past(d_dqs_t) && $past(d_dqs_c)) else $error("read postamble");
   chk_wr_pre: assert property ($rose(c_dqs_oe) |-> if (wpre_q)
      pre_two(c_dqs_t, c_dqs_c) else pre_one(c_dqs_t, c_dqs_c))
      else $error("write preamble length");
   chk_rd_pre: assert property ($rose(d_dqs_oe) && !train_q |->
      if (rpre_q) pre_two(d_dqs_t, d_dqs_c)
      else pre_one(d_dqs_t, d_dqs_c))
      else $error("read preamble length");
endmodule // ppbg_chk

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic rerr, wpre, rpre, train;
   int err_count = 0;
   int checked = 0;
   // ctrl, group, bank, data
   logic [81:0] rows [5] = '{
      {14'h0000, 4'h0, 64'h0123456789abcdef},
      {14'h0001, 4'h6, 64'hfedcba9876543210},
      {14'h0002, 4'h9, 64'h00ff00ff55aa55aa},
      {14'h003f, 4'hf, 64'hffffffff00000000},
      {14'h0201, 4'h5, 64'h8000000100000001}};
   ppbg_if ppbg_if_i();
   ppbg_ctl ppbg_ctl_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(ppbg_if_i.ctl)
   );
   ppbg_dev ppbg_dev_i
   (
      .bus(ppbg_if_i.dev), .presetn(presetn), .wr_pre_mode(wpre),
      .rd_pre_mode(rpre), .train_mode(train)
   );
   ppbg_chk ppbg_chk_i
   (
      .ck(ppbg_if_i.ck), .presetn(presetn), .cmd(ppbg_if_i.cmd),
      .bank_group_field(ppbg_if_i.bank_group_field), .ba(ppbg_if_i.ba),
      .addr(ppbg_if_i.addr), .c_dqs_t(ppbg_if_i.c_dqs_t),
      .c_dqs_c(ppbg_if_i.c_dqs_c), .c_dqs_oe(ppbg_if_i.c_dqs_oe),
      .d_dqs_t(ppbg_if_i.d_dqs_t), .d_dqs_c(ppbg_if_i.d_dqs_c),
      .d_dqs_oe(ppbg_if_i.d_dqs_oe), .d_dq(ppbg_if_i.d_dq)
   );
   task automatic report_and_stop;
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (int n = 0; n < 20 && pready !== 1'b1; n++)
      begin
         @(posedge pclk);
         if (n == 19)
            err_count++;
      end
      {rdat, rerr} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   // busy covers the whole burst, so polling also spaces the commands
   task automatic op(input logic [2:0] o, input logic [3:0] gb);
      apb(1'b1, ppbg_pkg::CMD_OFS, {25'h0, gb[1:0], gb[3:2], o});
      rdat = 32'h1;
      for (int n = 0; n < 100 && rdat[0] !== 1'b0; n++)
         apb(1'b0, ppbg_pkg::STAT_OFS, 32'h0);
      if (rdat[0] !== 1'b0)
         err_count++;
   endtask
   task automatic rd_chk(input logic [3:0] gb, input logic [63:0] exp);
      logic [31:0] lo;
      op(ppbg_pkg::OP_RD, gb);
      apb(1'b0, ppbg_pkg::RD0_OFS, 32'h0);
      lo = rdat;
      apb(1'b0, ppbg_pkg::RD1_OFS, 32'h0);
      check({rdat, lo}, exp);
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      #400000;
      err_count++;
      report_and_stop();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ppbg_pkg::CTRL_OFS, 32'h0);
      check(64'(rdat), 64'(ppbg_pkg::CTRL_RST));
      foreach (rows[i])
      begin
         apb(1'b1, ppbg_pkg::CTRL_OFS, 32'(rows[i][81:68]));
         op(ppbg_pkg::OP_MR2, 4'h0);
         op(ppbg_pkg::OP_MR4, 4'h0);
         check(64'({rpre, wpre}), 64'(rows[i][69:68]));
         apb(1'b1, ppbg_pkg::WD0_OFS, rows[i][31:0]);
         apb(1'b1, ppbg_pkg::WD1_OFS, rows[i][63:32]);
         op(ppbg_pkg::OP_WR, rows[i][67:64]);
         rd_chk(rows[i][67:64], rows[i][63:0]);
      end
      rd_chk(rows[0][67:64], rows[0][63:0]);
      // a second command while busy must be turned away
      apb(1'b1, ppbg_pkg::CMD_OFS, 32'(ppbg_pkg::OP_RD));
      op(ppbg_pkg::OP_RD, 4'h0);
      apb(1'b0, ppbg_pkg::STAT_OFS, 32'h0);
      check(64'(rdat[1]), 64'h1);
      apb(1'b1, ppbg_pkg::STAT_OFS, 32'h2);
      apb(1'b0, 8'h40, 32'h0);
      check(64'({rerr, rdat}), 64'h100000000);
      apb(1'b1, ppbg_pkg::CTRL_OFS, 32'h2000);
      op(ppbg_pkg::OP_MR4, 4'h0);
      apb(1'b0, ppbg_pkg::STAT_OFS, 32'h0);
      check(64'({train, rdat[2:1]}), 64'h1);
      apb(1'b1, ppbg_pkg::CTRL_OFS, 32'h0400);
      op(ppbg_pkg::OP_MR3, 4'h0);
      apb(1'b1, ppbg_pkg::CTRL_OFS, 32'h2400);
      op(ppbg_pkg::OP_MR4, 4'h0);
      repeat (20) @(posedge pclk);
      check(64'({train, ppbg_if_i.d_dqs_t, ppbg_if_i.d_dqs_c,
         ppbg_if_i.d_dq}), 64'h5ffff);
      apb(1'b1, ppbg_pkg::CTRL_OFS, 32'h0400);
      op(ppbg_pkg::OP_MR4, 4'h0);
      check(64'(train), 64'h0);
      report_and_stop();
   end
endmodule // tb_top
